/* File: fra_params.svh */
// Constants for the file-register execution unit: widths, reset values, encodings
`ifndef FRA_PARAMS_SVH
`define FRA_PARAMS_SVH

`define FRA_ADDR_W     7
`define FRA_DATA_W     8
`define FRA_FILE_DEPTH 128
`define FRA_ACC_RST    8'h00
`define FRA_ZERO_RST   1'b0
`define FRA_FILE_RST   8'h00
`define FRA_INC_STEP   8'h01
`define FRA_DEST_ACC   1'b0
`define FRA_DEST_FILE  1'b1

`endif

/* File: fra_pkg.sv */
// Types shared by the file-register execution unit
package fra_pkg;

	// The four file-register operations handled here
	typedef enum logic [1:0] {
		increment_reg_op,
		or_acc_with_reg_op,
		move_reg_op,
		move_acc_to_reg_op
	} fra_op_t;

endpackage : fra_pkg

/* File: fra_file_reg_exec.sv */
// Execution unit for increment, OR, move and store-accumulator file-register operations
//
// Operation
// RQ1: Increment reads the addressed register, adds one, sends sum to chosen destination.
// RQ2: Destination bit 0 writes the accumulator; bit 1 writes the addressed register.
// RQ3: OR combines accumulator and addressed register, result to chosen destination.
// RQ4: Move copies addressed register into accumulator, or back onto itself.
// RQ5: Increment, OR and move set the zero flag from their result.
// RQ6: Store-accumulator writes accumulator to register 0..127, flags untouched.
// RQ7: Each operation takes one word and finishes in one instruction cycle.
`timescale 1ns/10ps
`default_nettype none
`include "fra_params.svh"

module fra_file_reg_exec
	import fra_pkg::*;
#(
	parameter int ADDR_W = `FRA_ADDR_W,
	parameter int DATA_W = `FRA_DATA_W,
	parameter int DEPTH  = `FRA_FILE_DEPTH
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// Decoded instruction
	input  wire logic              instValid,
	input  wire fra_op_t           instOp,
	input  wire logic [ADDR_W-1:0] instAddr,
	input  wire logic              instDest,
	// Preload of the file by the rest of the core
	input  wire logic              fileLoadEn,
	input  wire logic [ADDR_W-1:0] fileLoadAddr,
	input  wire logic [DATA_W-1:0] fileLoadData,
	// Preload of the accumulator by the rest of the core
	input  wire logic              accLoadEn,
	input  wire logic [DATA_W-1:0] accLoadData,
	// Observation port of the file
	input  wire logic [ADDR_W-1:0] peekAddr,
	output logic      [DATA_W-1:0] peekData,
	// Core state
	output logic      [DATA_W-1:0] accOut,
	output logic                   zeroOut,
	output logic                   doneOut
);

	logic [DATA_W-1:0] fileMem [DEPTH];
	logic [DATA_W-1:0] acc_reg;
	logic              zero_reg;
	logic              done_reg;
	logic [DATA_W-1:0] peek_reg;
	logic [DATA_W-1:0] srcData;
	logic [DATA_W-1:0] result_next;
	logic              toFile;
	logic              toAcc;
	logic              flagOp;

	// Operand fetch is combinational so the whole operation fits one cycle
	assign srcData = fileMem[instAddr];

	// Result of the operation in flight
	always_comb begin
		result_next = srcData;
		case (instOp)
			increment_reg_op: begin
				result_next = srcData + DATA_W'(`FRA_INC_STEP); // RQ1
			end
			or_acc_with_reg_op: begin
				result_next = acc_reg | srcData; // RQ3
			end
			move_reg_op: begin
				result_next = srcData; // RQ4
			end
			move_acc_to_reg_op: begin
				result_next = acc_reg; // RQ6
			end
			default: begin
				result_next = srcData;
			end
		endcase
	end

	// Destination steering; the store-accumulator form always targets the file
	assign toFile = instValid && ((instOp == move_acc_to_reg_op) ||
		(instDest == `FRA_DEST_FILE)); // RQ2
	assign toAcc  = instValid && (instOp != move_acc_to_reg_op) &&
		(instDest == `FRA_DEST_ACC); // RQ2
	assign flagOp = instValid && (instOp != move_acc_to_reg_op); // RQ5

	// Data file; an executing write wins over a preload to the same word
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				fileMem[i] <= `FRA_FILE_RST;
			end
		end else begin
			if (fileLoadEn) begin
				fileMem[fileLoadAddr] <= fileLoadData;
			end
			if (toFile) begin
				fileMem[instAddr] <= result_next; // RQ2
			end
		end
	end

	// Accumulator; an executing write wins over a preload
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			acc_reg <= `FRA_ACC_RST;
		end else if (toAcc) begin
			acc_reg <= result_next; // RQ2
		end else if (accLoadEn) begin
			acc_reg <= accLoadData;
		end
	end

	// Zero flag; the store form leaves it alone so it can follow a test
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			zero_reg <= `FRA_ZERO_RST;
		end else if (flagOp) begin
			zero_reg <= (result_next == '0); // RQ5
		end
	end

	// Completion strobe, one cycle after every accepted operation
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= instValid; // RQ7
		end
	end

	// Registered observation read; sees the file as stored at the edge
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			peek_reg <= '0;
		end else begin
			peek_reg <= fileMem[peekAddr];
		end
	end

	assign accOut   = acc_reg;
	assign zeroOut  = zero_reg;
	assign doneOut  = done_reg;
	assign peekData = peek_reg;

	// Checks on the execution behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	inc_result_a: assert property ( // RQ1
		instValid && instOp == increment_reg_op && instDest == `FRA_DEST_ACC
		|=> acc_reg == DATA_W'($past(srcData) + DATA_W'(1)))
		else $error("increment result wrong in accumulator");

	file_dest_a: assert property ( // RQ2
		instValid && instOp != move_acc_to_reg_op && instDest == `FRA_DEST_FILE
		|=> fileMem[$past(instAddr)] == $past(result_next) &&
		acc_reg == ($past(accLoadEn) ? $past(accLoadData) : $past(acc_reg)))
		else $error("file destination not honoured");

	or_result_a: assert property ( // RQ3
		instValid && instOp == or_acc_with_reg_op && instDest == `FRA_DEST_ACC
		|=> acc_reg == ($past(acc_reg) | $past(srcData)))
		else $error("OR result wrong in accumulator");

	move_self_a: assert property ( // RQ4
		instValid && instOp == move_reg_op && instDest == `FRA_DEST_FILE && !fileLoadEn
		|=> fileMem[$past(instAddr)] == $past(srcData) &&
		acc_reg == ($past(accLoadEn) ? $past(accLoadData) : $past(acc_reg)))
		else $error("self move altered state");

	zero_update_a: assert property ( // RQ5
		flagOp |=> zero_reg == ($past(result_next) == '0))
		else $error("zero flag not from result");

	store_acc_a: assert property ( // RQ6
		instValid && instOp == move_acc_to_reg_op
		|=> fileMem[$past(instAddr)] == $past(acc_reg) && $stable(zero_reg))
		else $error("store of accumulator wrong");

	single_cycle_a: assert property ( // RQ7
		instValid |=> doneOut)
		else $error("operation not done in one cycle");

	no_spurious_a: assert property ( // RQ7
		!instValid |=> !doneOut)
		else $error("done without an operation");

	acc_hold_a: assert property ( // RQ6
		!toAcc && !accLoadEn |=> $stable(acc_reg))
		else $error("accumulator changed without a write");

	acc_preload_a: assert property ( // RQ2
		!toAcc && accLoadEn |=> acc_reg == $past(accLoadData))
		else $error("accumulator preload lost");

	zero_hold_a: assert property ( // RQ6
		!flagOp |=> $stable(zero_reg))
		else $error("zero flag changed without a flag update");

	move_acc_a: assert property ( // RQ4
		instValid && instOp == move_reg_op && instDest == `FRA_DEST_ACC
		|=> acc_reg == $past(srcData))
		else $error("move to accumulator wrong");

	// Main scenarios
	cov_inc_wrap_c:  cover property (instValid && instOp == increment_reg_op &&
		srcData == '1);
	cov_test_zero_c: cover property (instValid && instOp == move_reg_op &&
		instDest == `FRA_DEST_FILE && srcData == '0);
	cov_or_file_c:   cover property (instValid && instOp == or_acc_with_reg_op &&
		instDest == `FRA_DEST_FILE);
	cov_store_c:     cover property (instValid && instOp == move_acc_to_reg_op ##1
		instValid && instOp == move_reg_op);
	cov_acc_clash_c: cover property (toAcc && accLoadEn);

endmodule : fra_file_reg_exec

`default_nettype wire

/* File: tb_fra_file_reg_exec.sv */
// Self-checking testbench for the file-register execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fra_pkg::*;
	// Stimulus and observed state
	logic       mclk = 0, nrst = 0, instValid = 0, instDest = 0;
	logic       fileLoadEn = 0, accLoadEn = 0, zeroOut, doneOut;
	fra_op_t    instOp = move_reg_op;
	logic [6:0] instAddr = 0, fileLoadAddr = 0, peekAddr = 0;
	logic [7:0] fileLoadData = 0, accLoadData = 0, peekData, accOut;
	int         failures = 0;
	int         n_tests = 0;
	// 200 MHz clock
	always #2.5 mclk = ~mclk;
	fra_file_reg_exec i_fra_file_reg_exec (.mclk(mclk), .nrst(nrst),
		.instValid(instValid), .instOp(instOp), .instAddr(instAddr),
		.instDest(instDest), .fileLoadEn(fileLoadEn), .fileLoadAddr(fileLoadAddr),
		.fileLoadData(fileLoadData), .accLoadEn(accLoadEn), .accLoadData(accLoadData),
		.peekAddr(peekAddr), .peekData(peekData), .accOut(accOut),
		.zeroOut(zeroOut), .doneOut(doneOut));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// Inputs move 1 ns after the edge so sampling is never racy
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask : tick
	// Preload a file word and the accumulator together
	task automatic ld(input logic [6:0] a, input logic [7:0] f, input logic [7:0] w);
		{fileLoadEn, fileLoadAddr, fileLoadData} = {1'b1, a, f};
		{accLoadEn, accLoadData} = {1'b1, w};
		tick;
		{fileLoadEn, accLoadEn} = 2'b00;
	endtask : ld
	// Present one operation, peeking at the word it addresses
	task automatic put(input fra_op_t o, input logic [6:0] a, input logic d);
		instValid = 1'b1;
		instOp = o;
		instAddr = a;
		instDest = d;
		peekAddr = a;
	endtask : put
	// One operation; file word seen through peek one edge later
	task automatic op(input fra_op_t o, input logic [6:0] a, input logic d,
		input logic [7:0] w, input logic [7:0] f, input logic z);
		put(o, a, d);
		tick;
		instValid = 0;
		chk(doneOut, 1);
		chk(accOut, w);
		chk(zeroOut, z);
		tick;
		chk(doneOut, 0);
		chk(peekData, f);
	endtask : op
	task automatic t_inc;
		ld(5, 8'h41, 8'h10);
		op(increment_reg_op, 5, 0, 8'h42, 8'h41, 0);
		ld(6, 8'hff, 8'h00);
		op(increment_reg_op, 6, 1, 8'h00, 8'h00, 1);
		$display("increment done");
	endtask : t_inc
	task automatic t_or;
		ld(7, 8'h0c, 8'h30);
		op(or_acc_with_reg_op, 7, 0, 8'h3c, 8'h0c, 0);
		ld(8, 8'h00, 8'h00);
		op(or_acc_with_reg_op, 8, 1, 8'h00, 8'h00, 1);
		ld(8, 8'h81, 8'h42);
		op(or_acc_with_reg_op, 8, 1, 8'h42, 8'hc3, 0);
		$display("or done");
	endtask : t_or
	// Move onto itself tests for zero without changing the word
	task automatic t_mov;
		ld(9, 8'h00, 8'h55);
		op(move_reg_op, 9, 1, 8'h55, 8'h00, 1);
		ld(9, 8'h80, 8'h55);
		op(move_reg_op, 9, 0, 8'h80, 8'h80, 0);
		$display("move done");
	endtask : t_mov
	// Store to the top address leaves the zero flag alone
	task automatic t_sto;
		ld(126, 8'h00, 8'ha5);
		op(move_reg_op, 126, 1, 8'ha5, 8'h00, 1);
		ld(127, 8'h11, 8'ha5);
		op(move_acc_to_reg_op, 127, 0, 8'ha5, 8'ha5, 1);
		$display("store done");
	endtask : t_sto
	// Mid-run reset clears accumulator, flag and file
	task automatic t_rst;
		nrst = 0;
		tick;
		nrst = 1;
		peekAddr = 7'h7f;
		chk(accOut, 8'h00);
		chk(zeroOut, 8'h00);
		chk(doneOut, 8'h00);
		tick;
		chk(peekData, 8'h00);
		$display("reset done");
	endtask : t_rst
	// Back-to-back operations each see the state left by the one before
	task automatic t_b2b;
		ld(22, 8'h5a, 8'h00);
		put(increment_reg_op, 22, 1);
		tick;
		chk(zeroOut, 8'h00);
		put(move_acc_to_reg_op, 22, 0);
		tick;
		chk(zeroOut, 8'h00);
		chk(doneOut, 8'h01);
		put(move_reg_op, 22, 1);
		tick;
		instValid = 0;
		chk(zeroOut, 8'h01);
		chk(accOut, 8'h00);
		tick;
		chk(doneOut, 8'h00);
		chk(peekData, 8'h00);
		$display("back-to-back done");
	endtask : t_b2b
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	// Main sequence after a four-cycle reset
	initial begin
		repeat (4) tick;
		chk(accOut, 8'h00);
		chk(zeroOut, 8'h00);
		chk(doneOut, 8'h00);
		chk(peekData, 8'h00);
		nrst = 1;
		t_inc;
		t_or;
		t_mov;
		t_sto;
		t_rst;
		t_b2b;
		results;
	end
	// Watchdog well beyond the expected run
	initial begin
		#20000;
		failures++;
		results;
	end
endmodule : testbench
`default_nettype wire
